//--- core/prhg_pkg.sv
// Notes on behaviour
// - at start, test source for total failure; if failed, never release words
// - after a total failure in operation, drop words using later raw bits
// - run statistical online test at start-up and during operation, flag defects
// - hold output blocked until power-up test passes; block again on defect
// - online test runs continuously, catching weaknesses within a bounded window
// - words released are 8 or 16 bits wide
// - internal bits must carry Shannon entropy above 0.997 per bit
// - a continuous test on generated words besides the source failure test
package prhg_pkg;
	// total failure: this many equal raw bits in a row
	localparam int unsigned STUCK_LIMIT    = 32;
	// online test window and tolerated ones count band (monobit style)
	localparam int unsigned WIN_LEN        = 1024;
	localparam int unsigned ONES_LOW       = 448;
	localparam int unsigned ONES_HIGH      = 576;
	localparam int unsigned WORD_W         = 16;
	localparam int unsigned CNT_W          = 11;
	// bits per word in each delivered format
	localparam int unsigned NARROW_BITS    = 8;
	localparam int unsigned WIDE_BITS      = 16;
	// failure cause codes
	localparam logic [1:0]  FAIL_NONE      = 2'h0;
	localparam logic [1:0]  FAIL_TOTAL     = 2'h1;
	localparam logic [1:0]  FAIL_ONLINE    = 2'h2;
	localparam logic [1:0]  FAIL_REPEAT    = 2'h3;

	typedef enum logic [1:0] {
		ST_STARTUP = 2'b00,
		ST_RUN     = 2'b01,
		ST_FAILED  = 2'b10
	} prhg_state_type;

	typedef struct packed {
		prhg_state_type     state;
		logic               last_bit;
		logic [5:0]         run_len;
		logic [CNT_W-1:0]   win_cnt;
		logic [CNT_W-1:0]   ones_cnt;
		logic [WORD_W-1:0]  shift;
		logic [4:0]         nbits;
		logic [WORD_W-1:0]  prev_word;
		logic               have_prev;
		logic [WORD_W-1:0]  word_out;
		logic               valid_out;
		logic               fail_out;
		logic [1:0]         cause_out;
		logic               ready_out;
	} prhg_regs_type;

	// value after reset: gate closed, nothing flagged, start-up pending
	localparam prhg_regs_type REGS_RESET = '{
		state:     ST_STARTUP,
		last_bit:  1'b0,
		run_len:   6'h00,
		win_cnt:   11'h000,
		ones_cnt:  11'h000,
		shift:     16'h0000,
		nbits:     5'h00,
		prev_word: 16'h0000,
		have_prev: 1'b0,
		word_out:  16'h0000,
		valid_out: 1'b0,
		fail_out:  1'b0,
		cause_out: FAIL_NONE,
		ready_out: 1'b0
	};
endpackage : prhg_pkg

//--- core/prhg_gate.sv
`timescale 1ns/100ps
`default_nettype none
module prhg_gate (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rstn,
	// raw entropy source
	input  wire logic                          raw_bit,
	input  wire logic                          raw_valid,
	// consumer side
	input  wire logic                          wide_mode,
	output logic [prhg_pkg::WORD_W-1:0]        rnd_word,
	output logic                               rnd_valid,
	output logic                               healthy,
	output logic                               fail_flag,
	output logic [1:0]                         fail_cause
);
	// thresholds cut to the width of the counters they meet
	localparam logic [5:0]  STUCK_N  = 6'(prhg_pkg::STUCK_LIMIT);
	localparam logic [10:0] WIN_LAST = 11'(prhg_pkg::WIN_LEN - 1);
	localparam logic [10:0] ONES_MIN = 11'(prhg_pkg::ONES_LOW);
	localparam logic [10:0] ONES_MAX = 11'(prhg_pkg::ONES_HIGH);
	localparam logic [4:0]  NARROW_N = 5'(prhg_pkg::NARROW_BITS);
	localparam logic [4:0]  WIDE_N   = 5'(prhg_pkg::WIDE_BITS);

	prhg_pkg::prhg_regs_type r_reg;
	prhg_pkg::prhg_regs_type r_next;

	// run of equal raw bits; it stops at the limit
	// so a stuck source can never wrap it back to a small value
	function automatic logic [5:0] next_run(
		logic [5:0] run_len,
		logic       last_bit,
		logic       bit_in
	);
		logic [5:0] res;
		res = 6'h01;
		if (bit_in == last_bit) begin
			if (run_len < STUCK_N) begin
				res = run_len + 6'h01;
			end else begin
				res = run_len;
			end
		end
		return res;
	endfunction : next_run

	// ones count after taking one more bit of the window
	function automatic logic [10:0] ones_next(
		logic [10:0] ones,
		logic        bit_in
	);
		logic [10:0] res;
		res = ones;
		if (bit_in) begin
			res = ones + 11'h001;
		end
		return res;
	endfunction : ones_next

	// ones count of a finished window outside the tolerated band
	function automatic logic band_bad(
		logic [10:0] ones
	);
		logic res;
		res = (ones < ONES_MIN) || (ones > ONES_MAX);
		return res;
	endfunction : band_bad

	// bits in one word of the selected format
	function automatic logic [4:0] word_len(
		logic wide
	);
		logic [4:0] res;
		res = wide ? WIDE_N : NARROW_N;
		return res;
	endfunction : word_len

	// word as delivered: narrow words sit in the low byte, upper byte zero
	function automatic logic [prhg_pkg::WORD_W-1:0] fit_width(
		logic [prhg_pkg::WORD_W-1:0] shifted,
		logic                        wide
	);
		logic [prhg_pkg::WORD_W-1:0] res;
		if (wide) begin
			res = shifted;
		end else begin
			res = {8'h00, shifted[7:0]};
		end
		return res;
	endfunction : fit_width

	// every failure ends the same way; only reset leaves this state
	function automatic prhg_pkg::prhg_regs_type enter_failed(
		prhg_pkg::prhg_regs_type cur,
		logic [1:0]              cause
	);
		prhg_pkg::prhg_regs_type res;
		res = cur;
		res.state = prhg_pkg::ST_FAILED;
		res.cause_out = cause;
		res.fail_out = 1'b1;
		res.ready_out = 1'b0;
		res.valid_out = 1'b0;
		return res;
	endfunction : enter_failed

	always_comb begin
		logic                        take;
		logic                        stuck;
		logic                        win_end;
		logic                        win_bad;
		logic                        word_done;
		logic [prhg_pkg::WORD_W-1:0] new_word;
		logic [prhg_pkg::WORD_W-1:0] cand_word;
		logic                        repeat_hit;
		take = 1'b0;
		stuck = 1'b0;
		win_end = 1'b0;
		win_bad = 1'b0;
		word_done = 1'b0;
		new_word = '0;
		cand_word = '0;
		repeat_hit = 1'b0;
		r_next = r_reg;
		r_next.valid_out = 1'b0;

		// a failed gate takes no more raw bits
		take = raw_valid && (r_reg.state != prhg_pkg::ST_FAILED);

		if (take) begin
			// total failure test, armed from the very first bit
			r_next.run_len = next_run(r_reg.run_len, r_reg.last_bit,
				raw_bit);
			r_next.last_bit = raw_bit;
			stuck = (r_next.run_len >= STUCK_N);

			// online test: fixed window, always armed, never on request
			r_next.win_cnt = r_reg.win_cnt + 11'h001;
			r_next.ones_cnt = ones_next(r_reg.ones_cnt, raw_bit);
			win_end = (r_reg.win_cnt == WIN_LAST);
			win_bad = band_bad(r_next.ones_cnt);
			if (win_end) begin
				r_next.win_cnt = '0;
				r_next.ones_cnt = '0;
			end

			// word assembly, first bit taken ends as the top bit
			new_word = {r_reg.shift[prhg_pkg::WORD_W-2:0], raw_bit};
			r_next.shift = new_word;
			r_next.nbits = r_reg.nbits + 5'h01;
			word_done = (r_next.nbits == word_len(wide_mode));
			if (word_done) begin
				r_next.nbits = '0;
			end
			cand_word = fit_width(new_word, wide_mode);

			// repeat test at the delivered width: the shifter still holds
			// bits of older words above a narrow one
			repeat_hit = r_reg.have_prev
				&& (cand_word == r_reg.prev_word);

			case (r_reg.state)
				prhg_pkg::ST_STARTUP: begin
					// no word leaves before the power-up window has passed
					if (stuck) begin
						r_next = enter_failed(r_next,
							prhg_pkg::FAIL_TOTAL);
					end else if (win_end && win_bad) begin
						r_next = enter_failed(r_next,
							prhg_pkg::FAIL_ONLINE);
					end else if (win_end) begin
						r_next.state = prhg_pkg::ST_RUN;
						r_next.ready_out = 1'b1;
						r_next.nbits = '0;
					end
				end
				prhg_pkg::ST_RUN: begin
					if (stuck) begin
						// the word in progress holds later bits: drop it
						r_next = enter_failed(r_next,
							prhg_pkg::FAIL_TOTAL);
					end else if (win_end && win_bad) begin
						r_next = enter_failed(r_next,
							prhg_pkg::FAIL_ONLINE);
					end else if (word_done && repeat_hit) begin
						r_next = enter_failed(r_next,
							prhg_pkg::FAIL_REPEAT);
					end else if (word_done) begin
						r_next.prev_word = cand_word;
						r_next.have_prev = 1'b1;
						r_next.word_out = cand_word;
						r_next.valid_out = 1'b1;
					end
				end
				default: begin
					// unknown code: shut the gate rather than guess
					r_next = enter_failed(r_next,
						prhg_pkg::FAIL_TOTAL);
				end
			endcase
		end
	end

	// failed state is left only by reset: no words after any failure
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= prhg_pkg::REGS_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// every output is a register field
	assign rnd_word = r_reg.word_out;
	assign rnd_valid = r_reg.valid_out;
	assign healthy = r_reg.ready_out;
	assign fail_flag = r_reg.fail_out;
	assign fail_cause = r_reg.cause_out;
endmodule : prhg_gate
`default_nettype wire

//--- tb/prhg_gate_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module prhg_gate_asserts (
	// watched outputs
	input wire logic clk,
	input wire logic rstn,
	input wire logic rnd_valid,
	input wire logic healthy,
	input wire logic fail_flag,
	input wire logic [1:0] fail_cause);
	default clocking @(posedge clk); endclocking default disable iff (!rstn);
	sequence s_pulse; rnd_valid ##1 !rnd_valid; endsequence
	a_valid_ok: assert property (rnd_valid |-> healthy) else $error("early");
	a_valid_pulse: assert property (rnd_valid |-> s_pulse) else $error("long");
	a_fail_sticky: assert property (fail_flag |=> fail_flag) else $error("lost");
	a_fail_dark: assert property (fail_flag |-> !healthy) else $error("up");
	a_fail_quiet: assert property (fail_flag |-> !rnd_valid) else $error("out");
	a_cause_held: assert property (fail_flag |=> $stable(fail_cause)) else $error("c");
	a_cause_set: assert property (fail_flag |-> fail_cause != 2'h0) else $error("c0");
	a_health_drop: assert property ($fell(healthy) |-> fail_flag) else $error("h");
endmodule : prhg_gate_asserts
`default_nettype wire

//--- tb/prhg_consumer.sv
`timescale 1ns/100ps
`default_nettype none
module prhg_consumer (
	// word in, captured copy out
	input wire logic clk,
	input wire logic [15:0] rnd_word,
	input wire logic rnd_valid,
	output logic got,
	output logic [15:0] word);
	always_ff @(posedge clk) {got, word} <= {rnd_valid, rnd_word};
endmodule : prhg_consumer
`default_nettype wire

//--- tb/test_physical_rng_health_gate.sv
`timescale 1ns/100ps
`default_nettype none
module test_physical_rng_health_gate;
	logic clk = 0, raw_bit = 0, raw_valid = 0, wide_mode = 0, rstn, got;
	logic rnd_valid, healthy, fail_flag; logic [1:0] fail_cause;
	logic [15:0] rnd_word, seen, w, q[$];
	int fail_count = 0, checks = 0;
	always #5 clk = ~clk;
	prhg_gate uut (
		.clk(clk),
		.rstn(rstn),
		.raw_bit(raw_bit),
		.raw_valid(raw_valid),
		.wide_mode(wide_mode),
		.rnd_word(rnd_word),
		.rnd_valid(rnd_valid),
		.healthy(healthy),
		.fail_flag(fail_flag),
		.fail_cause(fail_cause)
	);
	prhg_consumer peer (
		.clk(clk),
		.rnd_word(rnd_word),
		.rnd_valid(rnd_valid),
		.got(got),
		.word(seen)
	);
	task automatic check(string n, logic [15:0] s, e);
		checks += 1; if (s !== e) fail_count += 1;
		if (s !== e) $display("[FAIL] %s exp %h seen %h", n, e, s);
	endtask : check
	task automatic send(logic [15:0] v, int n); raw_valid = 1;
		for (int i = n - 1; i >= 0; i--) begin raw_bit = v[i]; @(posedge clk) #1; end
	endtask : send
	task automatic tally_and_finish;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (!fail_count && checks) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// any word with nothing queued is a leak
	always @(posedge clk) if (got === 1'b1)
		check("word", seen, q.size() ? q.pop_front() : 'x);
	initial #200000 begin fail_count += 1; tally_and_finish; end
	initial begin
		void'($urandom(63718));
		for (int j = 4; j > 0; j--) begin
			rstn = 0; raw_valid = 0; repeat (16) @(posedge clk) #1; rstn = 1;
			repeat (64) send(j >= 3 ? 16'($urandom) : {15'h7fff, j[0]}, 16);
			raw_valid = 0; repeat (2) @(posedge clk) #1;
			if (j == 4) begin
				wide_mode = 1;
				q.push_back(16'h0001);
				q.push_back(16'hffff);
				send(16'h0001, 16);
				send(16'hffff, 16);
				send(16'hffff, 16);
			end
			for (int k = 0; k < 13 && j == 3; k++) begin
				wide_mode = k[3];
				if (k < 12) w = 16'({$urandom, 4'(k)}) & {{8{k[3]}}, 8'hff};
				if (k < 12) q.push_back(w);
				send(w, k[3] ? 16 : 8);
			end
			raw_valid = 0; repeat (2) @(posedge clk) #1;
			check("st", 16'({healthy, fail_flag, fail_cause}),
				16'(j == 4 ? 5 : 4 + j));
		end
		tally_and_finish;
	end
endmodule : test_physical_rng_health_gate
bind prhg_gate prhg_gate_asserts chk (
	.clk(clk),
	.rstn(rstn),
	.rnd_valid(rnd_valid),
	.healthy(healthy),
	.fail_flag(fail_flag),
	.fail_cause(fail_cause)
);
`default_nettype wire
